// ---- rtl/dtc_core.sv ----
// Conversion sequencer, alarm outputs and APB register file of the temperature sensor
//
// Behaviour
// - Reset pin high returns every register to its default; low means run.
// - Overtemperature output is open drain, active low.
// - Interrupt output is open drain, active low, shareable with the alert line.
// - Interrupt-style pin high or open: latched alert, cleared by host response.
// - Interrupt-style pin low: comparator mode, asserted on any remote limit violation.
// - Comparator mode releases only when back within limits or masked.
// - Standby pin low enters standby and keeps all registers.
// - Source select: high local, low remote, open both trip overtemperature.
// - Overtemperature asserts when selected temperature exceeds software or pin threshold.
// - Legacy format is sign plus seven bits, one degree, allows 8 Hz.
// - Extended remote resolution adds three fraction bits, only at 4 Hz or slower or single.
// - Lowest reading is 0 C, or -64 C with configuration bit 3 set.
// - Each channel integrates about 60 ms before its result forms.
// - Every sequence measures local then remote channel.
// - Sequence starts free running when halt is 0, or on single-conversion write.
// - Busy status is set while a sequence is in progress.
// - Reads return previous results until the whole sequence ends.
// - Configuration bit 5 selects discrete diode or substrate PNP remote sensor.
// - Halt bit 6 set is software standby, stops converter, keeps registers.
// - Single conversion runs in software standby, ignored in hardware standby.
// - Standby request during a sequence aborts it.
//
// Our own choices: the register offsets and the APB register port.
`timescale 1ns/1ps
`default_nettype none

module dtc_core #(
  parameter int INTEG_CYCLES     = dtc_pkg::INTEG_CYCLES,
  parameter int RATE_FAST_CYCLES = dtc_pkg::RATE_FAST_CYCLES
) (
  input  wire logic              pclk,
  input  wire logic              presetn,
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [7:0]        paddr,
  input  wire logic [31:0]       pwdata,
  output var  logic [31:0]       prdata,
  output var  logic              pready,
  output var  logic              pslverr,
  input  wire dtc_pkg::dtc_pins_t pins_i,
  input  wire dtc_pkg::dtc_raw_t  raw_i,
  input  wire logic              alert_response_ack,
  output var  logic              overtemp_alarm_n_out,
  output var  logic              overtemp_alarm_n_oe,
  output var  logic              alert_n_out,
  output var  logic              alert_n_oe,
  output var  logic              adc_enable,
  output var  logic              adc_remote_sel,
  output var  logic              remote_pnp_type
);

  dtc_pkg::dtc_regs_t r_reg;
  dtc_pkg::dtc_regs_t r_next;

  logic        setup;
  logic        access;
  logic        wr;
  logic        hw_standby_pin_n;
  logic        sw_standby_pin_n;
  logic        oneshot;
  logic        halt_write;
  logic        rate_tick;
  logic        start;
  logic        abort;
  logic        loc_hi;
  logic        loc_lo;
  logic        rem_hi;
  logic        rem_lo;
  logic        rem_viol;
  logic        any_viol;
  logic        ot_loc;
  logic        ot_rem;
  logic        ot_cond;
  logic        alert_clear;
  logic [7:0]  loc_th;
  logic [7:0]  rem_th;
  logic [31:0] period;
  logic [31:0] status;
  logic [10:0] loc_c;
  logic [10:0] rem_c;

  function automatic logic mapped(input logic [7:0] a);
    unique case (a)
      dtc_pkg::ADDR_LOCAL_TEMP, dtc_pkg::ADDR_REMOTE_TEMP, dtc_pkg::ADDR_REMOTE_FRAC,
      dtc_pkg::ADDR_STATUS, dtc_pkg::ADDR_CONFIG, dtc_pkg::ADDR_RATE,
      dtc_pkg::ADDR_ONESHOT, dtc_pkg::ADDR_LOCAL_HIGH, dtc_pkg::ADDR_LOCAL_LOW,
      dtc_pkg::ADDR_REMOTE_HIGH, dtc_pkg::ADDR_REMOTE_LOW, dtc_pkg::ADDR_LOCAL_OT,
      dtc_pkg::ADDR_REMOTE_OT: mapped = 1'b1;
      default:                 mapped = 1'b0;
    endcase
  endfunction : mapped

  // Floor of the reading depends on the range bit
  function automatic logic [10:0] clamp_raw(input logic [10:0] raw, input logic ext_range);
    logic signed [10:0] lo;
    lo = ext_range ? dtc_pkg::RAW_MIN_EXT : dtc_pkg::RAW_MIN_STD;
    clamp_raw = ($signed(raw) < lo) ? lo : raw;
  endfunction : clamp_raw

  always_comb begin
    r_next      = r_reg;
    setup       = psel && !penable && !r_reg.pready;
    access      = psel && penable && r_reg.pready;
    wr          = access && pwrite;
    hw_standby_pin_n     = !r_reg.pins_s2.standby_pin_n_n;
    sw_standby_pin_n     = r_reg.cfg[dtc_pkg::CFG_HALT_BIT];
    oneshot     = wr && (paddr == dtc_pkg::ADDR_ONESHOT) && !hw_standby_pin_n;
    halt_write  = wr && (paddr == dtc_pkg::ADDR_CONFIG) && pwdata[dtc_pkg::CFG_HALT_BIT];
    rate_tick   = !hw_standby_pin_n && !sw_standby_pin_n && (r_reg.rate_cnt == '0);
    start       = (rate_tick || oneshot) && (r_reg.state == dtc_pkg::DTC_IDLE);
    abort       = hw_standby_pin_n || (sw_standby_pin_n && !r_reg.one_run) || halt_write;
    period      = 32'(RATE_FAST_CYCLES) << (dtc_pkg::RATE_MAX_CODE - r_reg.rate);
    loc_c       = clamp_raw(raw_i.local_raw, r_reg.cfg[dtc_pkg::CFG_EXTRANGE_BIT]);
    rem_c       = clamp_raw(raw_i.remote_raw, r_reg.cfg[dtc_pkg::CFG_EXTRANGE_BIT]);
    loc_hi      = $signed(r_reg.local_temp) > $signed(r_reg.local_high);
    loc_lo      = $signed(r_reg.local_temp) < $signed(r_reg.local_low);
    rem_hi      = $signed(r_reg.remote_temp) > $signed(r_reg.remote_high);
    rem_lo      = $signed(r_reg.remote_temp) < $signed(r_reg.remote_low);
    rem_viol    = rem_hi || rem_lo;
    any_viol    = rem_viol || loc_hi || loc_lo;
    loc_th      = r_reg.local_ot_sw ? r_reg.local_ot : r_reg.pins_s2.crit;
    rem_th      = r_reg.remote_ot_sw ? r_reg.remote_ot : r_reg.pins_s2.crit;
    ot_loc      = $signed(r_reg.local_temp) > $signed(loc_th);
    ot_rem      = $signed(r_reg.remote_temp) > $signed(rem_th);
    alert_clear = alert_response_ack || (access && !pwrite && (paddr == dtc_pkg::ADDR_STATUS));
    status      = '0;
    status[dtc_pkg::STAT_BUSY_BIT]  = (r_reg.state != dtc_pkg::DTC_IDLE);
    status[dtc_pkg::STAT_LHIGH_BIT] = loc_hi;
    status[dtc_pkg::STAT_LLOW_BIT]  = loc_lo;
    status[dtc_pkg::STAT_RHIGH_BIT] = rem_hi;
    status[dtc_pkg::STAT_RLOW_BIT]  = rem_lo;
    status[dtc_pkg::STAT_OTL_BIT]   = ot_loc;
    status[dtc_pkg::STAT_OTR_BIT]   = ot_rem;
    unique case (r_reg.pins_s2.src_sel)
      dtc_pkg::SRC_LOCAL:  ot_cond = ot_loc;
      dtc_pkg::SRC_REMOTE: ot_cond = ot_rem;
      default:             ot_cond = ot_loc || ot_rem;
    endcase

    // Pins reach logic only through the second stage
    r_next.pins_s1 = pins_i;
    r_next.pins_s2 = r_reg.pins_s1;

    // Answer in the access phase with no wait state
    r_next.pready  = setup;
    r_next.pslverr = setup && !mapped(paddr);
    if (setup && !pwrite) begin
      unique case (paddr)
        dtc_pkg::ADDR_LOCAL_TEMP:  r_next.prdata = {24'h0, r_reg.local_temp};
        dtc_pkg::ADDR_REMOTE_TEMP: r_next.prdata = {24'h0, r_reg.remote_temp};
        dtc_pkg::ADDR_REMOTE_FRAC: r_next.prdata = {24'h0, r_reg.remote_frac, 5'h00};
        dtc_pkg::ADDR_STATUS:      r_next.prdata = status;
        dtc_pkg::ADDR_CONFIG:      r_next.prdata = {24'h0, r_reg.cfg};
        dtc_pkg::ADDR_RATE:        r_next.prdata = {29'h0, r_reg.rate};
        dtc_pkg::ADDR_LOCAL_HIGH:  r_next.prdata = {24'h0, r_reg.local_high};
        dtc_pkg::ADDR_LOCAL_LOW:   r_next.prdata = {24'h0, r_reg.local_low};
        dtc_pkg::ADDR_REMOTE_HIGH: r_next.prdata = {24'h0, r_reg.remote_high};
        dtc_pkg::ADDR_REMOTE_LOW:  r_next.prdata = {24'h0, r_reg.remote_low};
        dtc_pkg::ADDR_LOCAL_OT:    r_next.prdata = {24'h0, loc_th};
        dtc_pkg::ADDR_REMOTE_OT:   r_next.prdata = {24'h0, rem_th};
        default:                   r_next.prdata = '0;
      endcase
    end
    if (wr) begin
      unique case (paddr)
        dtc_pkg::ADDR_CONFIG:      r_next.cfg = pwdata[7:0];
        dtc_pkg::ADDR_RATE:        r_next.rate = pwdata[2:0];
        dtc_pkg::ADDR_LOCAL_HIGH:  r_next.local_high = pwdata[7:0];
        dtc_pkg::ADDR_LOCAL_LOW:   r_next.local_low = pwdata[7:0];
        dtc_pkg::ADDR_REMOTE_HIGH: r_next.remote_high = pwdata[7:0];
        dtc_pkg::ADDR_REMOTE_LOW:  r_next.remote_low = pwdata[7:0];
        dtc_pkg::ADDR_LOCAL_OT: begin
          r_next.local_ot    = pwdata[7:0];
          r_next.local_ot_sw = 1'b1;
        end
        dtc_pkg::ADDR_REMOTE_OT: begin
          r_next.remote_ot    = pwdata[7:0];
          r_next.remote_ot_sw = 1'b1;
        end
        default: ;
      endcase
    end
    r_next.pnp = r_reg.cfg[dtc_pkg::CFG_PNP_BIT];

    // Standby holds the rate timer at zero so leaving it starts at once
    if (hw_standby_pin_n || sw_standby_pin_n) begin
      r_next.rate_cnt = '0;
    end else if (r_reg.rate_cnt == '0) begin
      r_next.rate_cnt = period - 32'h1;
    end else begin
      r_next.rate_cnt = r_reg.rate_cnt - 32'h1;
    end

    unique case (r_reg.state)
      dtc_pkg::DTC_IDLE: begin
        if (start) begin
          r_next.state      = dtc_pkg::DTC_LOCAL;
          r_next.cnt        = 32'(INTEG_CYCLES - 1);
          r_next.adc_en     = 1'b1;
          r_next.adc_remote = 1'b0;
          r_next.one_run    = oneshot;
          r_next.ext_ok     = oneshot || (r_reg.rate <= dtc_pkg::RATE_EXTRES_MAX);
        end
      end
      dtc_pkg::DTC_LOCAL: begin
        if (r_reg.cnt == '0) begin
          r_next.local_hold = loc_c[10:dtc_pkg::FRAC_BITS];
          r_next.state      = dtc_pkg::DTC_REMOTE;
          r_next.cnt        = 32'(INTEG_CYCLES - 1);
          r_next.adc_remote = 1'b1;
        end else begin
          r_next.cnt = r_reg.cnt - 32'h1;
        end
      end
      dtc_pkg::DTC_REMOTE: begin
        if (r_reg.cnt == '0) begin
          r_next.remote_hold = rem_c;
          r_next.state       = dtc_pkg::DTC_COMMIT;
          r_next.adc_en      = 1'b0;
          r_next.adc_remote  = 1'b0;
        end else begin
          r_next.cnt = r_reg.cnt - 32'h1;
        end
      end
      dtc_pkg::DTC_COMMIT: begin
        // Both results land together
        r_next.local_temp  = r_reg.local_hold;
        r_next.remote_temp = r_reg.remote_hold[10:dtc_pkg::FRAC_BITS];
        r_next.remote_frac = (r_reg.ext_ok && r_reg.cfg[dtc_pkg::CFG_EXTRES_BIT])
                             ? r_reg.remote_hold[dtc_pkg::FRAC_BITS-1:0] : 3'h0;
        r_next.state       = dtc_pkg::DTC_IDLE;
        r_next.one_run     = 1'b0;
      end
    endcase
    if (abort && (r_reg.state != dtc_pkg::DTC_IDLE) && (r_reg.state != dtc_pkg::DTC_COMMIT)) begin
      // Half-finished results are dropped, previous ones stay readable
      r_next.state      = dtc_pkg::DTC_IDLE;
      r_next.adc_en     = 1'b0;
      r_next.adc_remote = 1'b0;
      r_next.one_run    = 1'b0;
    end

    // Open drain: level stays low, only the enable moves
    r_next.od_level = 1'b0;
    r_next.ot_oe    = ot_cond;
    if (any_viol) begin
      r_next.alert_latch = 1'b1;
    end else if (alert_clear) begin
      r_next.alert_latch = 1'b0;
    end
    if (r_reg.pins_s2.int_sel) begin
      r_next.alert_oe = r_next.alert_latch && !r_reg.cfg[dtc_pkg::CFG_MASK_BIT];
    end else begin
      r_next.alert_oe = rem_viol && !r_reg.cfg[dtc_pkg::CFG_MASK_BIT];
    end

    // Pin reset keeps the synchroniser and the bus answer running
    if (r_reg.pins_s2.rst) begin
      r_next         = dtc_pkg::REGS_RESET;
      r_next.pins_s1 = pins_i;
      r_next.pins_s2 = r_reg.pins_s1;
      r_next.pready  = setup;
      r_next.pslverr = setup && !mapped(paddr);
      r_next.prdata  = r_reg.prdata;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      r_reg <= dtc_pkg::REGS_RESET;
    end else begin
      r_reg <= r_next;
    end
  end

  assign prdata               = r_reg.prdata;
  assign pready               = r_reg.pready;
  assign pslverr              = r_reg.pslverr;
  assign overtemp_alarm_n_out = r_reg.od_level;
  assign overtemp_alarm_n_oe  = r_reg.ot_oe;
  assign alert_n_out          = r_reg.od_level;
  assign alert_n_oe           = r_reg.alert_oe;
  assign adc_enable           = r_reg.adc_en;
  assign adc_remote_sel       = r_reg.adc_remote;
  assign remote_pnp_type      = r_reg.pnp;

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  a_pin_reset_defaults: assert property (r_reg.pins_s2.rst |=>
    r_reg.cfg == dtc_pkg::CFG_RESET && r_reg.state == dtc_pkg::DTC_IDLE)
    else $error("pin reset did not restore defaults");
  a_overtemp_drive_low: assert property (overtemp_alarm_n_oe |-> !overtemp_alarm_n_out)
    else $error("overtemp driven high");
  a_alert_drive_low: assert property (alert_n_oe |-> !alert_n_out)
    else $error("alert driven high");
  a_alert_ack_release: assert property ((r_reg.pins_s2.int_sel && alert_clear
    && !any_viol) |=> !alert_n_oe)
    else $error("alert not released after response");
  a_comparator_assert: assert property ((!r_reg.pins_s2.int_sel && rem_viol
    && !r_reg.cfg[dtc_pkg::CFG_MASK_BIT] && !r_reg.pins_s2.rst) |=> alert_n_oe)
    else $error("comparator alert missing");
  a_comparator_release: assert property ((!r_reg.pins_s2.int_sel && !rem_viol)
    |=> !alert_n_oe)
    else $error("comparator alert held within limits");
  a_local_source_only: assert property ((r_reg.pins_s2.src_sel == dtc_pkg::SRC_LOCAL
    && !ot_loc) |=> !overtemp_alarm_n_oe)
    else $error("overtemp tripped by unselected channel");
  // Pin reset lets the idle timer fire, so its cycles are left out
  a_integ_period: assert property ((start && !r_reg.pins_s2.rst)
    |=> r_reg.cnt == 32'(INTEG_CYCLES - 1))
    else $error("integration period wrong");
  a_both_channels: assert property ((r_reg.state == dtc_pkg::DTC_LOCAL
    && r_reg.cnt == '0 && !abort && !r_reg.pins_s2.rst) |=> r_reg.state == dtc_pkg::DTC_REMOTE)
    else $error("remote channel skipped");
  a_range_floor: assert property ((r_reg.state == dtc_pkg::DTC_LOCAL && r_reg.cnt == '0
    && !r_reg.cfg[dtc_pkg::CFG_EXTRANGE_BIT] && !r_reg.pins_s2.rst) |=> !r_reg.local_hold[7])
    else $error("reading below 0 C in standard range");
  a_results_hold: assert property ((r_reg.state != dtc_pkg::DTC_COMMIT
    && !r_reg.pins_s2.rst) |=> $stable(r_reg.local_temp) && $stable(r_reg.remote_temp))
    else $error("results changed mid sequence");
  a_hw_standby_idle: assert property ((hw_standby_pin_n && r_reg.state == dtc_pkg::DTC_IDLE)
    |=> r_reg.state == dtc_pkg::DTC_IDLE)
    else $error("conversion started in hardware standby");
  a_standby_abort: assert property ((hw_standby_pin_n && r_reg.state == dtc_pkg::DTC_REMOTE)
    |=> r_reg.state == dtc_pkg::DTC_IDLE && !adc_enable)
    else $error("conversion not aborted");
  a_sw_standby_stop: assert property ((sw_standby_pin_n && !r_reg.one_run
    && r_reg.state == dtc_pkg::DTC_LOCAL) |=> r_reg.state == dtc_pkg::DTC_IDLE)
    else $error("software standby left converter running");
  a_oneshot_start: assert property ((oneshot && r_reg.state == dtc_pkg::DTC_IDLE
    && !r_reg.pins_s2.rst) |=> r_reg.state == dtc_pkg::DTC_LOCAL)
    else $error("single conversion not started");
  a_pnp_follows: assert property (!r_reg.pins_s2.rst
    |=> remote_pnp_type == $past(r_reg.cfg[dtc_pkg::CFG_PNP_BIT]))
    else $error("sensor type output wrong");
  a_frac_legacy: assert property ((r_reg.state == dtc_pkg::DTC_COMMIT
    && !r_reg.cfg[dtc_pkg::CFG_EXTRES_BIT] && !r_reg.pins_s2.rst) |=> r_reg.remote_frac == '0)
    else $error("fraction reported in legacy mode");
  a_fast_rate_legacy: assert property ((start && !oneshot && !r_reg.pins_s2.rst
    && r_reg.rate > dtc_pkg::RATE_EXTRES_MAX) |=> !r_reg.ext_ok)
    else $error("extended resolution allowed at fastest rate");

  c_sequence_done: cover property (r_reg.state == dtc_pkg::DTC_COMMIT);
  c_oneshot_standby: cover property (oneshot && sw_standby_pin_n && start);
  c_abort_seen: cover property (abort && r_reg.state == dtc_pkg::DTC_LOCAL);
  c_alert_cleared: cover property (r_reg.alert_latch ##1 !r_reg.alert_latch);
endmodule : dtc_core

`default_nettype wire

// ---- rtl/dtc_pkg.sv ----
// Constants, types and register map of the dual temperature conversion and alarm block
package dtc_pkg;
  localparam int CLK_HZ               = 20_000_000;
  localparam int INTEG_TIME_MS        = 60;
  localparam int INTEG_CYCLES         = CLK_HZ / 1000 * INTEG_TIME_MS;
  localparam int RATE_FAST_PERIOD_MS  = 125;
  localparam int RATE_FAST_CYCLES     = CLK_HZ / 1000 * RATE_FAST_PERIOD_MS;

  localparam logic [7:0] ADDR_LOCAL_TEMP  = 8'h00;
  localparam logic [7:0] ADDR_REMOTE_TEMP = 8'h04;
  localparam logic [7:0] ADDR_REMOTE_FRAC = 8'h08;
  localparam logic [7:0] ADDR_STATUS      = 8'h0c;
  localparam logic [7:0] ADDR_CONFIG      = 8'h10;
  localparam logic [7:0] ADDR_RATE        = 8'h14;
  localparam logic [7:0] ADDR_ONESHOT     = 8'h18;
  localparam logic [7:0] ADDR_LOCAL_HIGH  = 8'h1c;
  localparam logic [7:0] ADDR_LOCAL_LOW   = 8'h20;
  localparam logic [7:0] ADDR_REMOTE_HIGH = 8'h24;
  localparam logic [7:0] ADDR_REMOTE_LOW  = 8'h28;
  localparam logic [7:0] ADDR_LOCAL_OT    = 8'h2c;
  localparam logic [7:0] ADDR_REMOTE_OT   = 8'h30;

  localparam int CFG_MASK_BIT     = 7;
  localparam int CFG_HALT_BIT     = 6;
  localparam int CFG_PNP_BIT      = 5;
  localparam int CFG_EXTRES_BIT   = 4;
  localparam int CFG_EXTRANGE_BIT = 3;

  localparam int STAT_BUSY_BIT    = 7;
  localparam int STAT_LHIGH_BIT   = 6;
  localparam int STAT_LLOW_BIT    = 5;
  localparam int STAT_RHIGH_BIT   = 4;
  localparam int STAT_RLOW_BIT    = 3;
  localparam int STAT_OTL_BIT     = 1;
  localparam int STAT_OTR_BIT     = 0;

  localparam int FRAC_BITS        = 3;
  localparam int FRAC_LSB         = 5;

  localparam logic [7:0] CFG_RESET        = 8'h00;
  localparam logic [2:0] RATE_RESET       = 3'h5;
  localparam logic [2:0] RATE_MAX_CODE    = 3'h7;
  localparam logic [2:0] RATE_EXTRES_MAX  = 3'h6;
  localparam logic [7:0] HIGH_LIMIT_RESET = 8'h46;
  localparam logic [7:0] LOW_LIMIT_RESET  = 8'h00;

  localparam logic signed [10:0] RAW_MIN_STD = 11'sh000;
  localparam logic signed [10:0] RAW_MIN_EXT = 11'sh600;

  localparam logic [1:0] SRC_REMOTE = 2'h0;
  localparam logic [1:0] SRC_LOCAL  = 2'h1;

  typedef enum logic [1:0] {
    DTC_IDLE   = 2'b00,
    DTC_LOCAL  = 2'b01,
    DTC_REMOTE = 2'b11,
    DTC_COMMIT = 2'b10
  } dtc_state_t;

  // Pins from pad logic; src_sel[1] flags an open pin
  typedef struct packed {
    logic       rst;
    logic       standby_pin_n_n;
    logic       int_sel;
    logic [1:0] src_sel;
    logic [7:0] crit;
  } dtc_pins_t;

  // Front end results in eighths of a degree, two's complement
  typedef struct packed {
    logic [10:0] local_raw;
    logic [10:0] remote_raw;
  } dtc_raw_t;

  typedef struct packed {
    dtc_pins_t   pins_s1;
    dtc_pins_t   pins_s2;
    dtc_state_t  state;
    logic [31:0] cnt;
    logic [31:0] rate_cnt;
    logic        ext_ok;
    logic        one_run;
    logic [7:0]  local_hold;
    logic [10:0] remote_hold;
    logic [7:0]  local_temp;
    logic [7:0]  remote_temp;
    logic [2:0]  remote_frac;
    logic [7:0]  cfg;
    logic [2:0]  rate;
    logic [7:0]  local_high;
    logic [7:0]  local_low;
    logic [7:0]  remote_high;
    logic [7:0]  remote_low;
    logic [7:0]  local_ot;
    logic [7:0]  remote_ot;
    logic        local_ot_sw;
    logic        remote_ot_sw;
    logic        alert_latch;
    logic        pready;
    logic        pslverr;
    logic [31:0] prdata;
    logic        ot_oe;
    logic        alert_oe;
    logic        od_level;
    logic        adc_en;
    logic        adc_remote;
    logic        pnp;
  } dtc_regs_t;

  localparam dtc_regs_t REGS_RESET = '{
    state:       DTC_IDLE,
    cfg:         CFG_RESET,
    rate:        RATE_RESET,
    local_high:  HIGH_LIMIT_RESET,
    remote_high: HIGH_LIMIT_RESET,
    local_low:   LOW_LIMIT_RESET,
    remote_low:  LOW_LIMIT_RESET,
    default:     '0
  };
endpackage : dtc_pkg

// ---- test/dtc_host_model.sv ----
// Host side of the alarm pins: pull-ups and alert response
`timescale 1ns/1ps
`default_nettype none
module dtc_host_model (
  input  wire logic pclk,
  input  wire logic respond,
  input  wire logic alert_n_out,
  input  wire logic alert_n_oe,
  input  wire logic ot_n_out,
  input  wire logic ot_n_oe,
  output var  logic alert_wire,
  output var  logic ot_wire,
  output var  logic ack
);
  // Released lines float up to the pull-up level
  assign alert_wire = alert_n_oe ? alert_n_out : 1'b1;
  assign ot_wire    = ot_n_oe ? ot_n_out : 1'b1;
  initial ack = 1'b0;
  // One-cycle response pulse, repeated every other cycle while the alert stays low
  always @(posedge pclk) ack <= respond && !alert_wire && !ack;
endmodule : dtc_host_model
`default_nettype wire

// ---- test/tb_dual_temp_conversion_alarm.sv ----
// Self-checking bench of the dual temperature conversion block
`timescale 1ns/1ps
`default_nettype none
module tb_dual_temp_conversion_alarm;
  localparam int INTEG = 8;
  logic               pclk = 1'b0;
  logic               presetn = 1'b0;
  logic               psel = 1'b0;
  logic               penable = 1'b0;
  logic               pwrite = 1'b0;
  logic               respond = 1'b0;
  logic [7:0]         paddr = 8'h00;
  logic [31:0]        pwdata = 32'h0;
  logic [31:0]        prdata;
  logic [31:0]        v;
  logic               pready, pslverr, serr, ack, pnp;
  logic               ot_out, ot_oe, al_out, al_oe, al_w, ot_w, adc_en, adc_rem;
  dtc_pkg::dtc_pins_t pins = '{rst: 1'b0, standby_pin_n_n: 1'b1, int_sel: 1'b1, src_sel: 2'b10,
                               crit: 8'h50};
  dtc_pkg::dtc_raw_t  raw = '0;
  int                 fails = 0;
  int                 num_checks = 0;
  int                 cyc = 0;

  always #25 pclk = ~pclk;

  // Short integration keeps the run small
  dtc_core #(.INTEG_CYCLES(INTEG), .RATE_FAST_CYCLES(40)) i_dut (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .pins_i(pins), .raw_i(raw), .alert_response_ack(ack), .overtemp_alarm_n_out(ot_out),
    .overtemp_alarm_n_oe(ot_oe), .alert_n_out(al_out), .alert_n_oe(al_oe),
    .adc_enable(adc_en), .adc_remote_sel(adc_rem), .remote_pnp_type(pnp));

  dtc_host_model i_host (.pclk(pclk), .respond(respond), .alert_n_out(al_out),
    .alert_n_oe(al_oe), .ot_n_out(ot_out), .ot_n_oe(ot_oe), .alert_wire(al_w),
    .ot_wire(ot_w), .ack(ack));

  task automatic complete_run;
    $display("checks %0d mismatches %0d", num_checks, fails);
    if (fails == 0 && num_checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : complete_run

  always @(posedge pclk) begin
    cyc <= cyc + 1;
    if (cyc == 5000) begin
      fails = fails + 1;
      complete_run();
    end
  end

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      fails++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk

  task automatic wait_n(input int n);
    repeat (n) @(posedge pclk);
  endtask : wait_n

  // Request held until pready is seen at an edge
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    v = prdata;
    serr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask : wr

  task automatic rd(input logic [7:0] a);
    apb(1'b0, a, 32'h0);
  endtask : rd

  task automatic conv;
    wr(dtc_pkg::ADDR_ONESHOT, 32'h0);
    wait_n(2 * INTEG + 4);
  endtask : conv

  task automatic t_reset;
    rd(dtc_pkg::ADDR_CONFIG);
    chk(v, 32'h0);
    rd(dtc_pkg::ADDR_RATE);
    chk(v, 32'h5);
    rd(dtc_pkg::ADDR_REMOTE_HIGH);
    chk(v, 32'h46);
    rd(8'hfc);
    chk({31'h0, serr}, 32'h1);
    wr(dtc_pkg::ADDR_CONFIG, 32'h58);
    @(posedge pclk);
    pins.rst <= 1'b1;
    wait_n(4);
    pins.rst <= 1'b0;
    wait_n(3);
    rd(dtc_pkg::ADDR_CONFIG);
    chk(v, 32'h0);
  endtask : t_reset

  // Single conversion from software standby, old results kept while busy
  task automatic t_oneshot;
    wr(dtc_pkg::ADDR_CONFIG, 32'h60);
    @(posedge pclk);
    raw <= '{local_raw: 11'h7e8, remote_raw: 11'h0f5};
    wr(dtc_pkg::ADDR_ONESHOT, 32'h0);
    rd(dtc_pkg::ADDR_STATUS);
    chk({31'h0, v[7]}, 32'h1);
    chk({31'h0, pnp}, 32'h1);
    chk({30'h0, adc_en, adc_rem}, 32'h2);
    rd(dtc_pkg::ADDR_REMOTE_TEMP);
    chk(v, 32'h0);
    wait_n(INTEG);
    chk({30'h0, adc_en, adc_rem}, 32'h3);
    wait_n(INTEG);
    rd(dtc_pkg::ADDR_LOCAL_TEMP);
    chk(v, 32'h0);
    rd(dtc_pkg::ADDR_REMOTE_TEMP);
    chk(v, 32'h1e);
    rd(dtc_pkg::ADDR_REMOTE_FRAC);
    chk(v, 32'h0);
    rd(dtc_pkg::ADDR_STATUS);
    chk({31'h0, v[7]}, 32'h0);
  endtask : t_oneshot

  task automatic t_ext;
    wr(dtc_pkg::ADDR_CONFIG, 32'h58);
    @(posedge pclk);
    raw <= '{local_raw: 11'h4e0, remote_raw: 11'h7b3};
    conv();
    rd(dtc_pkg::ADDR_LOCAL_TEMP);
    chk(v, 32'hc0);
    rd(dtc_pkg::ADDR_REMOTE_TEMP);
    chk(v, 32'hf6);
    rd(dtc_pkg::ADDR_REMOTE_FRAC);
    chk(v, 32'h60);
  endtask : t_ext

  task automatic t_hwstby;
    @(posedge pclk);
    pins.standby_pin_n_n <= 1'b0;
    raw.remote_raw <= 11'h050;
    wait_n(4);
    conv();
    rd(dtc_pkg::ADDR_REMOTE_TEMP);
    chk(v, 32'hf6);
    rd(dtc_pkg::ADDR_CONFIG);
    chk(v, 32'h58);
    @(posedge pclk);
    pins.standby_pin_n_n <= 1'b1;
    wait_n(4);
  endtask : t_hwstby

  // Free run caught mid-sequence, then halted
  task automatic t_abort;
    int n;
    n = 0;
    v = 32'h0;
    wr(dtc_pkg::ADDR_CONFIG, 32'h18);
    while (v[7] !== 1'b1 && n < 20) begin
      n++;
      rd(dtc_pkg::ADDR_STATUS);
    end
    chk({31'h0, v[7]}, 32'h1);
    wr(dtc_pkg::ADDR_CONFIG, 32'h58);
    wait_n(2 * INTEG + 4);
    rd(dtc_pkg::ADDR_STATUS);
    chk({31'h0, v[7]}, 32'h0);
    chk({31'h0, adc_en}, 32'h0);
    rd(dtc_pkg::ADDR_REMOTE_TEMP);
    chk(v, 32'hf6);
  endtask : t_abort

  task automatic t_alarm;
    @(posedge pclk);
    pins.int_sel <= 1'b0;
    pins.src_sel <= 2'b00;
    raw <= '{local_raw: 11'h0a0, remote_raw: 11'h2d0};
    wait_n(4);
    conv();
    chk({30'h0, ot_w, ot_oe}, 32'h1);
    chk({31'h0, al_w}, 32'h0);
    pins.src_sel <= 2'b01;
    wait_n(4);
    chk({31'h0, ot_oe}, 32'h0);
    pins.src_sel <= 2'b10;
    wait_n(4);
    chk({31'h0, ot_oe}, 32'h1);
    wr(dtc_pkg::ADDR_REMOTE_OT, 32'h64);
    wait_n(2);
    chk({31'h0, ot_oe}, 32'h0);
    rd(dtc_pkg::ADDR_REMOTE_OT);
    chk(v, 32'h64);
    raw.remote_raw <= 11'h0a0;
    conv();
    chk({31'h0, al_oe}, 32'h0);
    pins.int_sel <= 1'b1;
    raw.remote_raw <= 11'h2d0;
    wait_n(4);
    conv();
    chk({31'h0, al_oe}, 32'h1);
    raw.remote_raw <= 11'h0a0;
    conv();
    chk({31'h0, al_oe}, 32'h1);
    respond <= 1'b1;
    wait_n(4);
    chk({31'h0, al_oe}, 32'h0);
    respond <= 1'b0;
  endtask : t_alarm

  initial begin
    wait_n(3);
    presetn <= 1'b1;
    wait_n(3);
    t_reset();
    t_oneshot();
    t_ext();
    t_hwstby();
    t_abort();
    t_alarm();
    complete_run();
  end
endmodule : tb_dual_temp_conversion_alarm
`default_nettype wire
